// file: src/gsr_defs.svh
// constants for the gripper status register bank: offsets, field
// positions, codes and timing counts; included by its bare name
`ifndef GSR_DEFS_SVH
`define GSR_DEFS_SVH
// first input register word and number of words (16 status bytes)
`define GSR_FIRST_INPUT_REG 16'h07d0
`define GSR_REG_SPAN 16'h0008
// status byte indices
`define GSR_BYTE_UNIT_STATUS 4'h0
`define GSR_BYTE_RESERVED 4'h1
`define GSR_BYTE_FAULT 4'h2
`define GSR_BYTE_TARGET 4'h3
`define GSR_BYTE_MEASURED 4'h4
`define GSR_BYTE_CURRENT 4'h5
// fields of the unit status byte
`define GSR_BIT_ACT 0
`define GSR_BIT_GTO 3
`define GSR_LSB_STATE 4
`define GSR_LSB_CONTACT 6
`define GSR_STA_RESET 2'h0
`define GSR_STA_ACTIVATING 2'h1
`define GSR_STA_DONE 2'h3
`define GSR_OBJ_MOVING 2'h0
`define GSR_OBJ_OPENING 2'h1
`define GSR_OBJ_CLOSING 2'h2
`define GSR_OBJ_AT_POS 2'h3
// fault codes
`define GSR_FLT_NONE 4'h0
`define GSR_FLT_DELAYED 4'h5
`define GSR_FLT_NO_ACT 4'h7
`define GSR_FLT_TEMP 4'h8
`define GSR_FLT_COMM 4'h9
`define GSR_FLT_UNDERVOLT 4'ha
`define GSR_FLT_AR_RUN 4'hb
`define GSR_FLT_INTERNAL 4'hc
`define GSR_FLT_ACT_FAIL 4'hd
`define GSR_FLT_OVERCUR 4'he
`define GSR_FLT_AR_DONE 4'hf
// temperature limits in degrees c (85 and 80)
`define GSR_TEMP_HIGH_C 8'h55
`define GSR_TEMP_LOW_C 8'h50
// timing
`define GSR_CLK_HZ 50000000
`define GSR_COMM_TIMEOUT_MS 1000
`define GSR_COMM_TIMEOUT_CYC (`GSR_CLK_HZ / 1000 * `GSR_COMM_TIMEOUT_MS)
`define GSR_BLINK_HALF_MS 250
`define GSR_BLINK_HALF_CYC (`GSR_CLK_HZ / 1000 * `GSR_BLINK_HALF_MS)
`endif

// file: src/gsr_pkg.sv
// types shared by the gripper status register bank
// assumes nothing beyond a systemverilog compiler
package gsr_pkg;
  // unit life cycle
  typedef enum logic [1:0] {
    gsr_st_reset, gsr_st_activating, gsr_st_active, gsr_st_auto_rel
  } gsr_state_t;
  // one 16-bit input register, first byte goes out first on the wire
  typedef struct packed {
    logic [7:0] second_byte;
    logic [7:0] first_byte;
  } gsr_word_t;
  // finger motion events from the motor control loop
  typedef struct packed {
    logic moving;
    logic contact_opening;
    logic contact_closing;
    logic at_position;
    logic slip_detected;
  } gsr_motion_t;
  // fault sources from supervision logic
  typedef struct packed {
    logic undervoltage;
    logic internal_fault;
    logic activation_failed;
    logic overcurrent;
    logic auto_release_done;
  } gsr_fault_in_t;
endpackage

// file: src/gsr_status_regs.sv
// status side of the gripper register memory: status bytes, fault code,
// brake, re-grasp and indicator control, and the input register read port
// assumes every input comes from logic on clk_sys; the serial framing and
// crc live outside and call the read port once per register word
`timescale 1ns/1ps
`default_nettype none
`include "gsr_defs.svh"

module gsr_status_regs #(
  parameter int COMM_TIMEOUT_CYC = `GSR_COMM_TIMEOUT_CYC, // one second
  parameter int BLINK_HALF_CYC = `GSR_BLINK_HALF_CYC // blink half period
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic activation_request,
  input wire logic go_to_request,
  input wire logic auto_release_request,
  input wire logic [7:0] target_position_request,
  input wire logic [7:0] speed_request,
  input wire logic [7:0] force_request,
  input wire logic activation_done,
  input wire gsr_pkg::gsr_motion_t motion,
  input wire gsr_pkg::gsr_fault_in_t faults,
  input wire logic [7:0] temperature_c,
  input wire logic [7:0] measured_position_in,
  input wire logic [7:0] motor_current_in,
  input wire logic [3:0] external_controller_fault,
  input wire logic host_frame_valid,
  input wire logic booting,
  input wire logic rd_req,
  input wire logic [15:0] rd_addr,
  output logic rd_ack,
  output logic rd_err,
  output gsr_pkg::gsr_word_t rd_data,
  output logic [7:0] unit_status,
  output logic [7:0] fault_code,
  output logic brake_engage,
  output logic high_torque_mode,
  output logic regrasp_enable,
  output logic regrasp_start,
  output logic [7:0] regrasp_force_limit,
  output logic [7:0] regrasp_speed_limit,
  output logic led_blue,
  output logic led_red
);
  localparam int CW = $clog2(COMM_TIMEOUT_CYC + 1);
  localparam int BW = $clog2(BLINK_HALF_CYC + 1);

  // registered state
  gsr_pkg::gsr_state_t state_r, state_nxt;
  logic act_prev_r; // last activation request, for edge detect
  logic [3:0] major_r, major_nxt; // latched major fault, 0 when none
  logic hot_r; // over-temperature with hysteresis
  logic [CW-1:0] comm_cnt_r; // cycles since last valid host frame
  logic [1:0] contact_r, contact_nxt; // contact field
  logic [1:0] pend_r; // contact code held one cycle behind the brake
  logic pend_vld_r;
  logic brake_r;
  logic [BW-1:0] blink_cnt_r;
  logic blink_r;
  logic [7:0] tgt_r, pos_r, cur_r;
  logic [3:0] flt_r;
  logic [7:0] status_r;
  logic regrasp_r;
  logic [7:0] force_lim_r, speed_lim_r;
  logic led_b_r, led_r_r;
  logic rd_ack_r, rd_err_r;
  gsr_pkg::gsr_word_t rd_data_r;

  // decode
  wire act_rise = activation_request & ~act_prev_r;
  wire [3:0] major_new; // major fault raised this cycle, 0 when none
  wire comm_lost = (comm_cnt_r == CW'(COMM_TIMEOUT_CYC));
  wire blink_tick = (blink_cnt_r == BW'(BLINK_HALF_CYC - 1));
  wire action_req = go_to_request | auto_release_request;
  wire is_active = (state_r == gsr_pkg::gsr_st_active);
  wire go_on = go_to_request & is_active;
  wire contact_evt = motion.contact_opening | motion.contact_closing;
  wire [1:0] contact_code = motion.contact_closing ? `GSR_OBJ_CLOSING :
                                                     `GSR_OBJ_OPENING;
  wire holding = (contact_r == `GSR_OBJ_CLOSING) |
                 (contact_r == `GSR_OBJ_OPENING);
  wire force_nonzero = (force_request != 8'h00);
  wire [1:0] sta_code; // unit state field
  wire [3:0] flt_nxt;
  wire [7:0] status_nxt;
  wire in_range;
  wire [15:0] rd_off;
  wire [3:0] byte_lo_idx;

  // major fault raised now; auto release overrides others in its state, both while running and once done
  function automatic logic [3:0] major_pick(
    input gsr_pkg::gsr_fault_in_t f, input gsr_pkg::gsr_state_t s);
    logic [3:0] c;
    c = `GSR_FLT_NONE;
    if (f.undervoltage) c = `GSR_FLT_UNDERVOLT;
    if (f.overcurrent) c = `GSR_FLT_OVERCUR;
    if (f.activation_failed) c = `GSR_FLT_ACT_FAIL;
    if (f.internal_fault) c = `GSR_FLT_INTERNAL;
    if (s == gsr_pkg::gsr_st_auto_rel) begin
      c = f.auto_release_done ? `GSR_FLT_AR_DONE : `GSR_FLT_AR_RUN;
    end
    return c;
  endfunction

  // status byte by index; reserved bytes read zero
  function automatic logic [7:0] byte_at(input logic [3:0] idx,
    input logic [7:0] st, input logic [7:0] fl, input logic [7:0] tg,
    input logic [7:0] ps, input logic [7:0] cu);
    logic [7:0] b;
    b = 8'h00;
    if (idx == `GSR_BYTE_UNIT_STATUS) b = st;
    if (idx == `GSR_BYTE_FAULT) b = fl;
    if (idx == `GSR_BYTE_TARGET) b = tg;
    if (idx == `GSR_BYTE_MEASURED) b = ps;
    if (idx == `GSR_BYTE_CURRENT) b = cu;
    return b;
  endfunction

  assign major_new = major_pick(faults, state_r);

  // unit state machine; a cleared activation request always wins
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      gsr_pkg::gsr_st_reset: begin
        if (act_rise) state_nxt = gsr_pkg::gsr_st_activating;
      end
      gsr_pkg::gsr_st_activating: begin
        if (auto_release_request) state_nxt = gsr_pkg::gsr_st_auto_rel;
        else if (faults.activation_failed) state_nxt = gsr_pkg::gsr_st_reset;
        else if (activation_done) state_nxt = gsr_pkg::gsr_st_active;
      end
      gsr_pkg::gsr_st_active: begin
        if (auto_release_request) state_nxt = gsr_pkg::gsr_st_auto_rel;
        else if (major_new != `GSR_FLT_NONE) begin
          state_nxt = gsr_pkg::gsr_st_reset; // reinit needed after major
        end
      end
      gsr_pkg::gsr_st_auto_rel: begin
        state_nxt = gsr_pkg::gsr_st_auto_rel; // left only through reset
      end
    endcase
    if (!activation_request) state_nxt = gsr_pkg::gsr_st_reset;
  end

  // major fault latch: a new fault wins over the clear in the same cycle
  always_comb begin
    major_nxt = major_r;
    if (act_rise || !activation_request) begin
      major_nxt = `GSR_FLT_NONE;
    end
    if (major_new != `GSR_FLT_NONE) major_nxt = major_new;
  end

  // contact field: contact beats motion so no detection is lost
  always_comb begin
    contact_nxt = contact_r;
    if (motion.moving || (go_to_request && !act_prev_r)) begin
      contact_nxt = `GSR_OBJ_MOVING;
    end
    if (motion.at_position) contact_nxt = `GSR_OBJ_AT_POS;
    if (pend_vld_r) contact_nxt = pend_r;
    if (!go_on) contact_nxt = `GSR_OBJ_MOVING; // meaningless
  end

  assign sta_code = (state_r == gsr_pkg::gsr_st_active) ?
                      `GSR_STA_DONE :
                    (state_r == gsr_pkg::gsr_st_activating) ?
                      `GSR_STA_ACTIVATING : `GSR_STA_RESET;

  // fault priority: major, temperature, comm loss, then priority faults
  assign flt_nxt = (major_r != `GSR_FLT_NONE) ? major_r :
                   hot_r ? `GSR_FLT_TEMP :
                   comm_lost ? `GSR_FLT_COMM :
                   (action_req && !activation_request) ?
                     `GSR_FLT_NO_ACT :
                   (go_to_request &&
                    state_r == gsr_pkg::gsr_st_activating) ?
                     `GSR_FLT_DELAYED : `GSR_FLT_NONE;

  assign status_nxt = {contact_r, sta_code, go_to_request, 2'h0,
                       activation_request};

  // input register decode: word n holds bytes 2n and 2n+1
  assign rd_off = rd_addr - `GSR_FIRST_INPUT_REG;
  assign in_range = (rd_addr >= `GSR_FIRST_INPUT_REG) &&
                    (rd_off < `GSR_REG_SPAN);
  assign byte_lo_idx = {rd_off[2:0], 1'b0};

  // edge detect, state and fault latches
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r <= gsr_pkg::gsr_st_reset;
      act_prev_r <= 1'b0;
      major_r <= `GSR_FLT_NONE;
    end else begin
      state_r <= state_nxt;
      act_prev_r <= activation_request;
      major_r <= major_nxt;
    end
  end

  // temperature hysteresis: set at the high limit, cleared below the low
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hot_r <= 1'b0;
    end else if (temperature_c >= `GSR_TEMP_HIGH_C) begin
      hot_r <= 1'b1;
    end else if (temperature_c < `GSR_TEMP_LOW_C) begin
      hot_r <= 1'b0;
    end
  end

  // host silence counter, saturates so the fault holds until traffic
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      comm_cnt_r <= '0;
    end else if (host_frame_valid) begin
      comm_cnt_r <= '0;
    end else if (!comm_lost) begin
      comm_cnt_r <= comm_cnt_r + CW'(1);
    end
  end

  // brake first, contact code one cycle later
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      brake_r <= 1'b1;
      pend_r <= `GSR_OBJ_MOVING;
      pend_vld_r <= 1'b0;
      contact_r <= `GSR_OBJ_MOVING;
    end else begin
      pend_vld_r <= contact_evt & go_on;
      pend_r <= contact_code;
      contact_r <= contact_nxt;
      if (contact_evt || motion.at_position || !go_on) begin
        brake_r <= 1'b1;
      end else if (motion.moving) begin
        brake_r <= 1'b0;
      end
    end
  end

  // re-grasp: on slip while holding, close toward the requested position
  // within the host's force and speed
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      regrasp_r <= 1'b0;
      force_lim_r <= 8'h00;
      speed_lim_r <= 8'h00;
    end else begin
      regrasp_r <= force_nonzero & go_on & holding &
                   motion.slip_detected;
      force_lim_r <= force_request;
      speed_lim_r <= speed_request;
    end
  end

  // indicator blink divider and colour select
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      blink_cnt_r <= '0;
      blink_r <= 1'b0;
      led_b_r <= 1'b1;
      led_r_r <= 1'b1;
    end else begin
      blink_cnt_r <= blink_tick ? '0 : blink_cnt_r + BW'(1);
      if (blink_tick) blink_r <= ~blink_r;
      led_b_r <= booting | (flt_r < `GSR_FLT_TEMP) |
                 ((flt_r >= `GSR_FLT_UNDERVOLT) & blink_r);
      led_r_r <= booting | (flt_r == `GSR_FLT_TEMP) |
                 (flt_r == `GSR_FLT_COMM) |
                 ((flt_r >= `GSR_FLT_UNDERVOLT) & ~blink_r);
    end
  end

  // status bytes, registered so every read sees a coherent snapshot
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      status_r <= 8'h00;
      flt_r <= `GSR_FLT_NONE;
      tgt_r <= 8'h00;
      pos_r <= 8'h00;
      cur_r <= 8'h00;
    end else begin
      status_r <= status_nxt;
      flt_r <= flt_nxt;
      tgt_r <= target_position_request;
      pos_r <= measured_position_in;
      cur_r <= motor_current_in;
    end
  end

  // read port: answer one cycle after the request
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_ack_r <= 1'b0;
      rd_err_r <= 1'b0;
      rd_data_r <= '0;
    end else begin
      rd_ack_r <= rd_req;
      rd_err_r <= rd_req & ~in_range;
      if (rd_req) begin
        rd_data_r.first_byte <= in_range ? byte_at(byte_lo_idx,
          status_r, fault_code, tgt_r, pos_r, cur_r) : 8'h00;
        rd_data_r.second_byte <= in_range ? byte_at(byte_lo_idx + 4'h1,
          status_r, fault_code, tgt_r, pos_r, cur_r) : 8'h00;
      end
    end
  end

  assign unit_status = status_r;
  assign fault_code = {external_controller_fault, flt_r};
  assign brake_engage = brake_r;
  assign high_torque_mode = force_nonzero;
  assign regrasp_enable = force_nonzero;
  assign regrasp_start = regrasp_r;
  assign regrasp_force_limit = force_lim_r;
  assign regrasp_speed_limit = speed_lim_r;
  assign led_blue = led_b_r;
  assign led_red = led_r_r;
  assign rd_ack = rd_ack_r;
  assign rd_err = rd_err_r;
  assign rd_data = rd_data_r;

  // checks
  property p_act_echo;
    @(posedge clk_sys) disable iff (rst)
    1'b1 |=> unit_status[`GSR_BIT_ACT] == $past(activation_request);
  endproperty
  a_act_echo: assert property (p_act_echo)
    else $error("activation echo mismatch");

  property p_gto_echo;
    @(posedge clk_sys) disable iff (rst)
    1'b1 |=> unit_status[`GSR_BIT_GTO] == $past(go_to_request);
  endproperty
  a_gto_echo: assert property (p_gto_echo)
    else $error("motion echo mismatch");

  property p_no_sta2;
    @(posedge clk_sys) disable iff (rst)
    unit_status[5:4] != 2'h2 && unit_status[2:1] == 2'h0;
  endproperty
  a_no_sta2: assert property (p_no_sta2)
    else $error("illegal state code or reserved bit set");

  property p_act_clear;
    @(posedge clk_sys) disable iff (rst)
    // a fault raised in the first low cycle still latches, so both
    // cycles must be free of new faults before the clear can show
    !activation_request && major_new == 4'h0 ##1
      !activation_request && major_new == 4'h0
      |=> unit_status[5:4] == 2'h0 && fault_code[3:0] < 4'ha;
  endproperty
  a_act_clear: assert property (p_act_clear)
    else $error("reset did not clear state or fault");

  property p_major_hold;
    @(posedge clk_sys) disable iff (rst)
    fault_code[3:0] >= 4'ha && activation_request && !act_rise
      |=> fault_code[3:0] >= 4'ha;
  endproperty
  a_major_hold: assert property (p_major_hold)
    else $error("major fault dropped without reset");

  property p_comm;
    @(posedge clk_sys) disable iff (rst)
    comm_lost && major_r == 4'h0 && !hot_r |=> fault_code[3:0] == 4'h9;
  endproperty
  a_comm: assert property (p_comm)
    else $error("comm loss not reported");

  property p_hot;
    @(posedge clk_sys) disable iff (rst)
    temperature_c >= 8'h55 ##1 major_r == 4'h0 |=> fault_code[3:0] == 4'h8;
  endproperty
  a_hot: assert property (p_hot)
    else $error("over-temperature not reported");

  property p_brake_first;
    @(posedge clk_sys) disable iff (rst)
    go_on && motion.contact_closing ##1 go_on
      |-> brake_engage ##2 unit_status[7:6] == 2'h2;
  endproperty
  a_brake_first: assert property (p_brake_first)
    else $error("contact reported without brake");

  property p_motion_clear;
    @(posedge clk_sys) disable iff (rst)
    motion.moving && !motion.at_position && !pend_vld_r
      |=> ##1 unit_status[7:6] == 2'h0;
  endproperty
  a_motion_clear: assert property (p_motion_clear)
    else $error("motion did not clear contact status");

  property p_read;
    @(posedge clk_sys) disable iff (rst)
    rd_req && rd_addr == 16'h07d1
      |=> rd_ack && !rd_err && rd_data.first_byte == $past(fault_code);
  endproperty
  a_read: assert property (p_read)
    else $error("word 0x07d1 does not carry the fault byte first");

  property p_regrasp;
    @(posedge clk_sys) disable iff (rst)
    force_request == 8'h00 |=> !regrasp_start;
  endproperty
  a_regrasp: assert property (p_regrasp)
    else $error("re-grasp at zero force");

endmodule // gsr_status_regs

`default_nettype wire

// file: testbench/gsr_host_model.sv
// host side model: reads status words and keeps the link watchdog fed
// assumes the read port answers one to eight cycles after a taken request
`timescale 1ns/1ps
`default_nettype none
module gsr_host_model (
  input wire logic clk_sys,
  input wire logic keep_alive,
  input wire logic rd_ack,
  input wire logic rd_err,
  input wire gsr_pkg::gsr_word_t rd_data,
  output logic rd_req,
  output logic [15:0] rd_addr,
  output logic host_frame_valid,
  output logic obj_lost
);
  logic [3:0] beat_r = 4'h0; // frame spacing counter
  logic [1:0] last_obj = 2'h0; // contact code seen on the last read
  initial begin
    rd_req = 1'h0;
    rd_addr = 16'h07d0;
    host_frame_valid = 1'h0;
    obj_lost = 1'h0;
  end
  // one frame every 16 cycles keeps the link watchdog quiet
  always @(posedge clk_sys) begin
    beat_r <= beat_r + 4'h1;
    host_frame_valid <= keep_alive && (beat_r == 4'hf);
  end
  // request is a one-cycle pulse; the answer is taken at the edge where
  // the acknowledge is sampled high
  task automatic read(input logic [15:0] a, output gsr_pkg::gsr_word_t d,
                      output logic e, output bit ok);
    ok = 0;
    @(posedge clk_sys);
    rd_req <= 1'h1;
    rd_addr <= a;
    @(posedge clk_sys);
    rd_req <= 1'h0; // taken here; holding it up would read twice
    for (int i = 0; i < 8 && !ok; i++) begin
      @(posedge clk_sys);
      ok = rd_ack;
    end
    d = rd_data; // first_byte is the one sent first
    e = rd_err;
    // contact code only means something while a move is requested
    if (a == 16'h07d0 && d.first_byte[3]) begin
      obj_lost = last_obj == 2'h2 && d.first_byte[7:6] == 2'h3;
      last_obj = d.first_byte[7:6];
    end
  endtask
endmodule // gsr_host_model
`default_nettype wire

// file: testbench/tb_gripper_status_registers.sv
// self-checking bench for the status register bank
// assumes short watchdog and blink counts set at the instance
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin #1; checks++; if ((a) !== (b)) begin n_fail++; \
  $display("[ERR] %0t: got %h want %h", $time, a, b); end end
module tb_gripper_status_registers;
  logic clk_sys = 1'h0, rst = 1'h1, activation_request = 1'h0;
  logic go_to_request = 1'h0, auto_release_request = 1'h0;
  logic activation_done = 1'h0, booting = 1'h0, keep_alive = 1'h1;
  logic [7:0] target_position_request = 8'h00, speed_request = 8'h20;
  logic [7:0] force_request = 8'h00, temperature_c = 8'h19;
  logic [7:0] measured_position_in = 8'h5a, motor_current_in = 8'h33;
  logic [3:0] external_controller_fault = 4'h6; // passed through
  gsr_pkg::gsr_motion_t motion = '0;
  gsr_pkg::gsr_fault_in_t faults = '0;
  logic rd_req, rd_ack, rd_err, host_frame_valid, obj_lost;
  logic brake_engage, high_torque_mode, regrasp_enable, regrasp_start;
  logic led_blue, led_red;
  logic [15:0] rd_addr;
  logic [7:0] unit_status, fault_code, regrasp_force_limit;
  logic [7:0] regrasp_speed_limit;
  gsr_pkg::gsr_word_t rd_data;
  // last two steps run auto release; the done flag only counts inside it
  logic [4:0] fsrc [6] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h00, 5'h01};
  logic [3:0] fcode [6] = '{4'ha, 4'hc, 4'hd, 4'he, 4'hb, 4'hf};
  int checks = 0, n_fail = 0;
  initial forever #10 clk_sys = ~clk_sys;
  gsr_status_regs #(.COMM_TIMEOUT_CYC(50), .BLINK_HALF_CYC(4)) i_dut (
    .clk_sys(clk_sys), .rst(rst), .activation_request(activation_request),
    .go_to_request(go_to_request),
    .auto_release_request(auto_release_request),
    .target_position_request(target_position_request),
    .speed_request(speed_request), .force_request(force_request),
    .activation_done(activation_done), .motion(motion), .faults(faults),
    .temperature_c(temperature_c),
    .measured_position_in(measured_position_in),
    .motor_current_in(motor_current_in),
    .external_controller_fault(external_controller_fault),
    .host_frame_valid(host_frame_valid), .booting(booting),
    .rd_req(rd_req), .rd_addr(rd_addr), .rd_ack(rd_ack), .rd_err(rd_err),
    .rd_data(rd_data), .unit_status(unit_status), .fault_code(fault_code),
    .brake_engage(brake_engage), .high_torque_mode(high_torque_mode),
    .regrasp_enable(regrasp_enable), .regrasp_start(regrasp_start),
    .regrasp_force_limit(regrasp_force_limit),
    .regrasp_speed_limit(regrasp_speed_limit),
    .led_blue(led_blue), .led_red(led_red));
  gsr_host_model i_host (
    .clk_sys(clk_sys), .keep_alive(keep_alive), .rd_ack(rd_ack),
    .rd_err(rd_err), .rd_data(rd_data), .rd_req(rd_req),
    .rd_addr(rd_addr), .host_frame_valid(host_frame_valid),
    .obj_lost(obj_lost));
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // verdict in one place; a hung read ends here too
  task automatic summarize();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // read one word and compare data and error flag
  task automatic rd(input logic [15:0] a, input logic [15:0] w,
                    input logic ew);
    gsr_pkg::gsr_word_t d;
    logic e;
    bit ok;
    i_host.read(a, d, e, ok);
    if (!ok) begin
      n_fail++;
      $display("[ERR] %0t: read not answered", $time);
      summarize();
    end
    `CHK(d, w);
    `CHK(e, ew);
  endtask
  // idle after reset, reserved and unmapped words
  task automatic t_reset();
    `CHK(unit_status, 8'h00);
    `CHK(brake_engage, 1'h1);
    rd(16'h07d0, 16'h0000, 1'h0);
    rd(16'h07d1, 16'h0060, 1'h0);
    rd(16'h07d3, 16'h0000, 1'h0);
    rd(16'h07d8, 16'h0000, 1'h1);
    rd(16'h07cf, 16'h0000, 1'h1);
  endtask
  // go without activation, then activation with a deferred go
  task automatic t_act();
    tick(1); go_to_request <= 1'h1;
    tick(4); `CHK(fault_code[3:0], 4'h7);
    `CHK(unit_status[3], 1'h1);
    tick(1); go_to_request <= 1'h0; activation_request <= 1'h1;
    tick(4); `CHK(unit_status[0], 1'h1);
    `CHK(unit_status[5:4], 2'h1);
    tick(1); go_to_request <= 1'h1;
    tick(4); `CHK(fault_code[3:0], 4'h5);
    tick(1); activation_done <= 1'h1;
    tick(1); activation_done <= 1'h0;
    tick(4); `CHK(unit_status[5:4], 2'h3);
    `CHK(fault_code[3:0], 4'h0);
  endtask
  // contact, slip, loss of object, motion and byte echoes
  task automatic t_contact();
    logic seen;
    seen = 1'h0;
    tick(1); force_request <= 8'h40; target_position_request <= 8'hc8;
    motion <= 5'h10;
    tick(4); `CHK(brake_engage, 1'h0);
    tick(1); motion <= 5'h04;
    tick(1); `CHK(brake_engage, 1'h1);
    `CHK(unit_status[7:6], 2'h0);
    tick(3); `CHK(unit_status[7:6], 2'h2);
    rd(16'h07d0, 16'h00b9, 1'h0);
    tick(1); motion <= 5'h05;
    tick(1); motion <= 5'h04;
    // the pulse lasts one cycle, so look at every cycle
    repeat (4) begin
      #1 seen = seen | regrasp_start;
      @(posedge clk_sys);
    end
    `CHK(seen, 1'h1);
    `CHK(regrasp_force_limit, 8'h40);
    `CHK(regrasp_speed_limit, 8'h20);
    `CHK(high_torque_mode, 1'h1);
    tick(1); motion <= 5'h02;
    tick(4); `CHK(unit_status[7:6], 2'h3);
    rd(16'h07d0, 16'h00f9, 1'h0);
    `CHK(obj_lost, 1'h1);
    tick(1); motion <= 5'h10;
    tick(4); `CHK(unit_status[7:6], 2'h0);
    tick(1); motion <= 5'h08;
    tick(4); `CHK(unit_status[7:6], 2'h1);
    rd(16'h07d1, 16'hc860, 1'h0);
    rd(16'h07d2, 16'h335a, 1'h0);
    tick(1); go_to_request <= 1'h0; motion <= '0; force_request <= 8'h00;
    tick(4); `CHK(unit_status[3], 1'h0);
    `CHK(high_torque_mode, 1'h0);
    `CHK(regrasp_enable, 1'h0);
  endtask
  // temperature hysteresis and link watchdog
  task automatic t_minor();
    tick(1); temperature_c <= 8'h54;
    tick(4); `CHK(fault_code[3:0], 4'h0);
    tick(1); temperature_c <= 8'h55;
    tick(4); `CHK(fault_code[3:0], 4'h8);
    `CHK(led_red, 1'h1);
    `CHK(led_blue, 1'h0);
    tick(1); temperature_c <= 8'h52;
    tick(4); `CHK(fault_code[3:0], 4'h8);
    tick(1); temperature_c <= 8'h4f;
    tick(4); `CHK(fault_code[3:0], 4'h0);
    `CHK(led_blue, 1'h1);
    tick(1); keep_alive <= 1'h0;
    tick(30); `CHK(fault_code[3:0], 4'h0);
    tick(40); `CHK(fault_code[3:0], 4'h9);
    tick(1); keep_alive <= 1'h1;
    tick(20); `CHK(fault_code[3:0], 4'h0);
  endtask
  // the first four major faults latch after their cause is gone; the last two are read in auto release, one while it runs and one once it is done
  task automatic t_major();
    for (int i = 0; i < 6; i++) begin
      tick(1);
      faults <= fsrc[i];
      auto_release_request <= (i > 3);
      tick(3); auto_release_request <= 1'h0;
      // the done flag is a level that stands until the unit is reset
      if (i < 5) faults <= '0;
      tick(6); `CHK(fault_code[3:0], fcode[i]);
      `CHK(led_red, ~led_blue);
      tick(1); activation_request <= 1'h0; faults <= '0;
      tick(3); `CHK(fault_code[3:0], 4'h0);
      `CHK(unit_status[5:4], 2'h0);
      tick(1); activation_request <= 1'h1;
    end
  endtask
  initial begin
    tick(8); rst <= 1'h0;
    tick(2);
    t_reset();
    t_act();
    t_contact();
    t_minor();
    t_major();
    tick(1); booting <= 1'h1;
    tick(3); `CHK(led_blue & led_red, 1'h1);
    summarize();
  end
endmodule // tb_gripper_status_registers
`default_nettype wire
